// ===== hdtvf_pkg.sv
// Constants, codes and carrier types for the HDTV parallel line formatter.
// Assumes one luminance sample clock drives every sequential element.
package hdtvf_pkg;

  // Line timing, in luminance sample clocks
  localparam logic [11:0] HDTVF_LINE_LEN_1125  = 12'h898;  // 2200
  localparam logic [11:0] HDTVF_LINE_LEN_1250  = 12'h900;  // 2304
  localparam logic [11:0] HDTVF_BLANK_LEN_1125 = 12'h118;  // 280
  localparam logic [11:0] HDTVF_BLANK_LEN_1250 = 12'h180;  // 384
  localparam logic [11:0] HDTVF_HREF_POS_1125  = 12'h058;  // 88
  localparam logic [11:0] HDTVF_HREF_POS_1250  = 12'h080;  // 128
  localparam logic [11:0] HDTVF_ACTIVE_LEN     = 12'h780;  // 1920
  localparam logic [11:0] HDTVF_TRS_LEN        = 12'h004;  // Words per timing code
  localparam logic [11:0] HDTVF_CNT_ONE        = 12'h001;

  // Word codes, 10-bit scale with two fractional LSBs
  localparam logic [9:0] HDTVF_TRS_ONES   = 10'h3FF;
  localparam logic [9:0] HDTVF_TRS_ZERO   = 10'h000;
  localparam logic [9:0] HDTVF_VID_MIN    = 10'h004;  // 1.00
  localparam logic [9:0] HDTVF_VID_MAX    = 10'h3FB;  // 254.75
  localparam logic [9:0] HDTVF_VID_MAX8   = 10'h3F8;  // 254.00
  localparam logic [9:0] HDTVF_BLACK      = 10'h040;  // 16.00
  localparam logic [9:0] HDTVF_PEAK       = 10'h3AC;  // 235.00
  localparam logic [9:0] HDTVF_C_ZERO     = 10'h200;  // 128.00
  localparam logic [9:0] HDTVF_C_MIN      = 10'h040;  // 16.00
  localparam logic [9:0] HDTVF_C_MAX      = 10'h3C0;  // 240.00
  localparam logic [9:0] HDTVF_LSB2_MASK  = 10'h3FC;  // Clears two fractional LSBs

  // Information word bit positions
  localparam int HDTVF_XYZ_ONE = 9;
  localparam int HDTVF_XYZ_F   = 8;
  localparam int HDTVF_XYZ_V   = 7;
  localparam int HDTVF_XYZ_H   = 6;
  localparam int HDTVF_XYZ_P3  = 5;
  localparam int HDTVF_XYZ_P2  = 4;
  localparam int HDTVF_XYZ_P1  = 3;
  localparam int HDTVF_XYZ_P0  = 2;

  // Buffer shape
  localparam int HDTVF_FIFO_DEPTH = 8;
  localparam int HDTVF_SAMP_W     = 10;

  // One input pixel: Y/G, Cb/B, Cr/R
  typedef struct packed {
    logic [9:0] cr_r;
    logic [9:0] cb_b;
    logic [9:0] y_g;
  } hdtvf_pix_t;

  // One output word: ch2 only used in RGB mode
  typedef struct packed {
    logic [9:0] ch2;
    logic [9:0] ch1;
    logic [9:0] ch0;
  } hdtvf_word_t;

  localparam int HDTVF_PIX_W = $bits(hdtvf_pix_t);

endpackage : hdtvf_pkg

// ===== hdtvf_fifo.sv
// Small synchronous FIFO carrying pixels into the line formatter.
// Assumes one clock; writes when wr_valid_i and wr_ready_o, reads likewise.
`timescale 1ns/1ps
module hdtvf_fifo #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Fill side
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  input  wire logic [WIDTH-1:0] wr_data_i,
  // Drain side
  output logic                  rd_valid_o,
  input  wire logic             rd_ready_i,
  output logic [WIDTH-1:0]      rd_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);
  localparam logic [AW:0] CNT_ONE   = (AW+1)'(1);
  localparam logic [AW-1:0] PTR_ONE = AW'(1);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             ready_r;
  wire              do_wr;
  wire              do_rd;
  wire  [AW:0]      count_nxt;

  // Ready from a flop, valid from the occupancy count
  assign wr_ready_o = ready_r;
  assign rd_valid_o = (count_r != '0);
  assign rd_data_o  = mem_r[rd_ptr_r];
  assign do_wr      = wr_valid_i & wr_ready_o;
  assign do_rd      = rd_ready_i & rd_valid_o;
  assign count_nxt  = (do_wr && !do_rd) ? count_r + CNT_ONE :
                      (do_rd && !do_wr) ? count_r - CNT_ONE : count_r;

  // Storage, written only
  always_ff @(posedge clk_i) begin
    if (do_wr) mem_r[wr_ptr_r] <= wr_data_i;
  end

  // Pointers and count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      ready_r  <= 1'b1;
    end else begin
      if (do_wr) wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + PTR_ONE;
      if (do_rd) rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + PTR_ONE;
      count_r  <= count_nxt;
      ready_r  <= (count_nxt != DEPTH_CNT);
    end
  end

endmodule : hdtvf_fifo

// ===== hdtvf_formatter.sv
// Source-side line formatter and line timer for the HDTV parallel link.
// Assumes CLK_I is the luminance sample clock and configuration is static.
// Assumes field bits are steady on the last clock of each line.
// Assumes the pixel source keeps the buffer ahead of the active run.
// Assumes the destination only listens; nothing comes back.
//
// What this block does
// R01: One-way link, single source to single destination.
// R02: Samples are 8- or 10-bit uniform PCM.
// R03: Timing codes 10-bit only in 1250 system.
// R04: 20-bit words multiplex Cb and Cr.
// R05: Words alternate Cb then Cr from first.
// R06: Both chroma samples taken from odd position.
// R07: Two 10-bit LSBs are fractional quarter steps.
// R08: 8-bit words get two zero LSBs appended.
// R09: 8-bit timing codes use eight MSBs only.
// R10: Reserved extreme levels never sent as video.
// R11: Black 16, peak 235, chroma zero 128.
// R12: 1125 system also carries 30-bit RGB words.
// R13: Line is 2200 or 2304 clocks long.
// R14: Line starts 88 or 128 before sync.
// R15: Active video starts 192 or 256 after sync.
// R16: Blanking lasts 280 or 384 clocks.
// R17: Field boundaries fall on digital line starts.
// R18: Timing code is four words: preamble plus info.
// R19: Info word carries F, V, H and protection.
// R20: F and V change only at line-start EAV.
// R21: SAV precedes, EAV follows each video block.
// R22: 1920 active samples between SAV and EAV.
// R23: Static inputs select line system and width.
`timescale 1ns/1ps
module hdtvf_formatter
  import hdtvf_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RSTN_I,
  // Static configuration
  input  wire logic        SYS_1250_I,
  input  wire logic        WIDTH8_I,
  input  wire logic        RGB_MODE_I,
  // Field state from the frame sequencer
  input  wire logic        FIELD_ID_I,
  input  wire logic        VBLANK_I,
  // Pixel stream in
  input  wire logic        PIX_VALID_I,
  output logic             PIX_READY_O,
  input  wire hdtvf_pix_t  PIX_DATA_I,
  // Link words out, one direction only
  output hdtvf_word_t      WORD_O,
  output logic             ACTIVE_O,
  output logic             EAV_O,
  output logic             SAV_O,
  output logic             LINE_START_O,
  output logic             HREF_O,
  output logic             UNDERRUN_O
);

  // Timing code word for one phase of a four-word code.
  // Phase 0 is all ones, phases 1 and 2 all zeros, phase 3 the info word.
  // Protection bits let the receiver correct one error in the top eight bits.
  // Narrow 1125 codes clear the two fraction bits of every word,
  // so the all-ones preamble becomes 3FC there.
  function automatic logic [9:0] trs_word(input logic [1:0] ph, input logic f,
                                          input logic v, input logic h,
                                          input logic narrow);
    logic [9:0] w;
    w = HDTVF_TRS_ZERO;
    unique case (ph)
      2'h0: w = HDTVF_TRS_ONES;                                          // R18
      2'h1: w = HDTVF_TRS_ZERO;
      2'h2: w = HDTVF_TRS_ZERO;
      2'h3: begin
        // Protection bits: P3 V^H, P2 F^H, P1 F^V, P0 F^V^H
        w[HDTVF_XYZ_ONE] = 1'b1;                                         // R19
        w[HDTVF_XYZ_F]   = f;
        w[HDTVF_XYZ_V]   = v;
        w[HDTVF_XYZ_H]   = h;
        w[HDTVF_XYZ_P3]  = v ^ h;
        w[HDTVF_XYZ_P2]  = f ^ h;
        w[HDTVF_XYZ_P1]  = f ^ v;
        w[HDTVF_XYZ_P0]  = f ^ v ^ h;
      end
    endcase
    trs_word = narrow ? (w & HDTVF_LSB2_MASK) : w;                       // R09
    return trs_word;
  endfunction : trs_word

  // Keeps a video sample out of the reserved ranges.
  // Narrow samples lose their fraction bits before the limit test,
  // so the narrow top limit is the highest whole level left for video.
  // Codes 0.00 to 0.75 and 255.00 up never leave as video.
  function automatic logic [9:0] clip_vid(input logic [9:0] s, input logic narrow);
    logic [9:0] t;
    t = narrow ? (s & HDTVF_LSB2_MASK) : s;                              // R08
    if (t < HDTVF_VID_MIN) t = HDTVF_VID_MIN;                            // R10
    else if (!narrow && t > HDTVF_VID_MAX) t = HDTVF_VID_MAX;            // R07
    else if (narrow && t > HDTVF_VID_MAX8) t = HDTVF_VID_MAX8;
    clip_vid = t;
    return clip_vid;
  endfunction : clip_vid

  // Line position state, segments in line order
  // All four codes are legal, so the decode needs no default arm
  typedef enum logic [1:0] {
    HDTVF_SEG_EAV   = 2'b00,
    HDTVF_SEG_BLANK = 2'b01,
    HDTVF_SEG_SAV   = 2'b10,
    HDTVF_SEG_ACT   = 2'b11
  } hdtvf_seg_t;

  // Line counter and field bits
  logic [11:0]  cnt_r;
  logic [11:0]  cnt_nxt;
  logic         field_r;
  logic         vblank_r;

  // Chroma pairing state
  logic         chroma_ph_r;
  logic [9:0]   cr_hold_r;
  logic [9:0]   cr_hold_nxt;

  // Word being built and the buffer head
  hdtvf_word_t  word_nxt;
  hdtvf_seg_t   seg;
  hdtvf_pix_t   fifo_data;
  logic         fifo_valid;
  logic         fifo_pop;

  // Line layout, counter value n in sample clocks:
  //   0 .. 3              end code, three preamble words then the info word
  //   4 .. blank-5        blanking words, black luma and zero chroma
  //   blank-4 .. blank-1  start code, same shape with H low
  //   blank .. m-1        active run, one buffered pixel per clock
  // HREF_O marks n = 88 or 128, the analogue sync reference, and video
  // starts 192 or 256 clocks after it. Outputs lag the count by one clock,
  // so every word and flag seen outside belongs to the previous count.
  // The blanking interval holds both codes, 280 or 384 clocks in all.

  // Timing constants chosen by the line system; RGB exists only in 1125
  wire [11:0] line_len  = SYS_1250_I ? HDTVF_LINE_LEN_1250  : HDTVF_LINE_LEN_1125;  // R23
  wire [11:0] blank_len = SYS_1250_I ? HDTVF_BLANK_LEN_1250 : HDTVF_BLANK_LEN_1125; // R16
  wire [11:0] href_pos  = SYS_1250_I ? HDTVF_HREF_POS_1250  : HDTVF_HREF_POS_1125;  // R14

  // Derived positions and decoded options
  wire [11:0] sav_pos   = blank_len - HDTVF_TRS_LEN;
  wire        line_end  = (cnt_r == line_len - HDTVF_CNT_ONE);                     // R13
  wire        narrow_v  = WIDTH8_I;                                                // R02
  wire        narrow_t  = WIDTH8_I & ~SYS_1250_I;                                  // R03
  wire        rgb_on    = RGB_MODE_I & ~SYS_1250_I;                                // R12
  wire [1:0]  trs_ph    = cnt_r[1:0];

  // Segment decode; active run is line less blanking, 1920 words.
  // Both timing codes start on a multiple of four, so the low counter
  // bits give the word phase inside a code directly.
  assign seg = (cnt_r < HDTVF_TRS_LEN) ? HDTVF_SEG_EAV :                           // R14
               (cnt_r < sav_pos)       ? HDTVF_SEG_BLANK :
               (cnt_r < blank_len)     ? HDTVF_SEG_SAV :                           // R21
                                         HDTVF_SEG_ACT;                            // R22
  assign cnt_nxt = line_end ? '0 : cnt_r + HDTVF_CNT_ONE;

  // Pop one pixel per active sample clock
  assign fifo_pop = (seg == HDTVF_SEG_ACT);                                        // R15

  // Clipped channels of the pixel at the buffer head. In luma plus chroma
  // mode word k carries Cb of pixel k when k is even and Cr of pixel k-1
  // when k is odd; the chroma of every second pixel is dropped.
  wire [9:0]  vid_y     = clip_vid(fifo_data.y_g, narrow_v);
  wire [9:0]  vid_cb    = clip_vid(fifo_data.cb_b, narrow_v);
  wire [9:0]  vid_cr    = clip_vid(fifo_data.cr_r, narrow_v);

  // Timing code words for this count, end code with H high
  wire [9:0]  trs_eav   = trs_word(trs_ph, field_r, vblank_r, 1'b1, narrow_t);
  wire [9:0]  trs_sav   = trs_word(trs_ph, field_r, vblank_r, 1'b0, narrow_t);

  // Next values of the one-bit link flags
  wire        act_nxt   = (seg == HDTVF_SEG_ACT);
  wire        eav_nxt   = (seg == HDTVF_SEG_EAV);
  wire        sav_nxt   = (seg == HDTVF_SEG_SAV);
  wire        ls_nxt    = (cnt_r == '0);
  wire        href_nxt  = (cnt_r == href_pos);
  wire        urun_nxt  = fifo_pop & ~fifo_valid;

  // Output word selection
  always_comb begin
    word_nxt    = '0;
    cr_hold_nxt = cr_hold_r;
    unique case (seg)
      // Four end-code words, same value on every used channel
      HDTVF_SEG_EAV: begin
        word_nxt.ch0 = trs_eav;                                                  // R21
        word_nxt.ch1 = trs_eav;
        word_nxt.ch2 = rgb_on ? trs_eav : '0;
      end
      // Start code, H low
      HDTVF_SEG_SAV: begin
        word_nxt.ch0 = trs_sav;
        word_nxt.ch1 = trs_sav;
        word_nxt.ch2 = rgb_on ? trs_sav : '0;
      end
      // Blanking: black luma, zero chroma
      HDTVF_SEG_BLANK: begin
        word_nxt.ch0 = HDTVF_BLACK;                                              // R11
        word_nxt.ch1 = rgb_on ? HDTVF_BLACK : HDTVF_C_ZERO;
        word_nxt.ch2 = rgb_on ? HDTVF_BLACK : '0;
      end
      // Active run from the buffer head; an empty buffer gives black
      HDTVF_SEG_ACT: begin
        if (rgb_on) begin
          word_nxt.ch0 = fifo_valid ? vid_y  : HDTVF_BLACK;
          word_nxt.ch1 = fifo_valid ? vid_cb : HDTVF_BLACK;
          word_nxt.ch2 = fifo_valid ? vid_cr : HDTVF_BLACK;
        end else begin
          word_nxt.ch0 = fifo_valid ? vid_y : HDTVF_BLACK;                       // R04
          if (!chroma_ph_r) begin
            // Odd sample: send its Cb, keep its Cr for the next word
            word_nxt.ch1 = fifo_valid ? vid_cb : HDTVF_C_ZERO;                   // R05
            cr_hold_nxt  = fifo_valid ? vid_cr : HDTVF_C_ZERO;                   // R06
          end else begin
            word_nxt.ch1 = cr_hold_r;                                            // R06
          end
        end
      end
    endcase
  end

  // Line counter, free running; never stalled by the buffer, since a
  // stall would move every code; an empty buffer sends black instead.
  // Reset parks it on the first end-code word.
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) cnt_r <= '0;
    else         cnt_r <= cnt_nxt;                                               // R13
  end

  // Field bits taken only as a new line begins.
  // Sampling on the last clock puts the change on the first end-code
  // word, so a field boundary never falls inside a line.
  // Reset value marks the first line as blanking.
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      field_r  <= 1'b0;
      vblank_r <= 1'b1;
    end else if (line_end) begin
      field_r  <= FIELD_ID_I;                                                    // R20
      vblank_r <= VBLANK_I;                                                      // R17
    end
  end

  // Chroma phase restarts at first active sample, so every line
  // opens with Cb; an underrun mid-pair keeps the phase running
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      chroma_ph_r <= 1'b0;
      cr_hold_r   <= HDTVF_C_ZERO;
    end else begin
      chroma_ph_r <= (seg == HDTVF_SEG_ACT) ? ~chroma_ph_r : 1'b0;              // R05
      cr_hold_r   <= cr_hold_nxt;
    end
  end

  // Link word register, one clock behind the counter
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) WORD_O <= '0;
    else         WORD_O <= word_nxt;                                             // R01
  end

  // Link flag registers, aligned with the word they mark
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ACTIVE_O     <= 1'b0;
      EAV_O        <= 1'b0;
      SAV_O        <= 1'b0;
      LINE_START_O <= 1'b0;
      HREF_O       <= 1'b0;
      UNDERRUN_O   <= 1'b0;
    end else begin
      ACTIVE_O     <= act_nxt;
      EAV_O        <= eav_nxt;
      SAV_O        <= sav_nxt;
      LINE_START_O <= ls_nxt;                                                    // R14
      HREF_O       <= href_nxt;
      UNDERRUN_O   <= urun_nxt;
    end
  end

  // Pixel buffer in the data path.
  // Pops happen only in the active run, so the buffer fills during
  // blanking and its ready stays low until the first active word.
  // Eight words of slack cover a source that lags by a few clocks.
  hdtvf_fifo #(
    .WIDTH (HDTVF_PIX_W),
    .DEPTH (HDTVF_FIFO_DEPTH)
  ) u_fifo (
    .clk_i      (CLK_I),
    .rst_n_i    (RSTN_I),
    .wr_valid_i (PIX_VALID_I),
    .wr_ready_o (PIX_READY_O),
    .wr_data_i  (PIX_DATA_I),
    .rd_valid_o (fifo_valid),
    .rd_ready_i (fifo_pop),
    .rd_data_o  (fifo_data)
  );

endmodule : hdtvf_formatter

// ===== hdtvf_formatter_chk.sv
// Port checker for the HDTV line formatter: line timing, codes, levels.
// Assumes static configuration and one clock with async active-low reset.
`timescale 1ns/1ps
module hdtvf_formatter_chk
  import hdtvf_pkg::*;
(
  // Clock and reset
  input wire logic        CLK_I,
  input wire logic        RSTN_I,
  // Configuration and field state
  input wire logic        SYS_1250_I,
  input wire logic        WIDTH8_I,
  input wire logic        RGB_MODE_I,
  input wire logic        FIELD_ID_I,
  input wire logic        VBLANK_I,
  // Pixel side
  input wire logic        PIX_VALID_I,
  input wire logic        PIX_READY_O,
  input wire hdtvf_pix_t  PIX_DATA_I,
  // Link side
  input wire hdtvf_word_t WORD_O,
  input wire logic        ACTIVE_O,
  input wire logic        EAV_O,
  input wire logic        SAV_O,
  input wire logic        LINE_START_O,
  input wire logic        HREF_O,
  input wire logic        UNDERRUN_O
);
  logic [11:0] cnt_r;
  logic [11:0] act_r;
  logic        seen_r;
  // Expected counter values at line end and at first active word
  wire  [11:0] line_last  = SYS_1250_I ? 12'h8FF : 12'h897;
  wire  [11:0] blank_last = SYS_1250_I ? 12'h17F : 12'h117;
  wire  [9:0]  xw         = WORD_O.ch0;

  // Clocks since line start and active words seen this line
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cnt_r  <= 12'h000;
      act_r  <= 12'h000;
      seen_r <= 1'b0;
    end else begin
      cnt_r  <= LINE_START_O ? 12'h000 : cnt_r + 12'h001;
      act_r  <= LINE_START_O ? 12'h000 : act_r + {11'h000, ACTIVE_O};
      seen_r <= seen_r | LINE_START_O;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  a_line_len: assert property (LINE_START_O && seen_r |-> cnt_r == line_last)
    else $error("line length wrong");
  a_href_1125: assert property (LINE_START_O && !SYS_1250_I |-> ##88 HREF_O)
    else $error("sync reference misplaced");
  a_href_1250: assert property (LINE_START_O && SYS_1250_I |-> ##128 HREF_O)
    else $error("sync reference misplaced");
  a_blank_len: assert property ($rose(ACTIVE_O) |-> cnt_r == blank_last)
    else $error("blanking length wrong");
  a_active_len: assert property ($fell(ACTIVE_O) |-> act_r == HDTVF_ACTIVE_LEN)
    else $error("active word count wrong");
  a_eav_words: assert property ($rose(EAV_O) |-> LINE_START_O ##1 EAV_O [*3] ##1 !EAV_O)
    else $error("end code length wrong");
  a_sav_video: assert property ($fell(SAV_O) |-> ACTIVE_O && $past(SAV_O, 4))
    else $error("start code not before video");
  a_eav_follows: assert property ($fell(ACTIVE_O) |-> EAV_O && LINE_START_O)
    else $error("end code not after video");
  a_xyz_bits: assert property (EAV_O && $past(EAV_O, 3) |-> xw[9] && xw[6] && xw[5] == (xw[7] ^ xw[6]) && xw[4] == (xw[8] ^ xw[6]) && xw[3] == (xw[8] ^ xw[7]) && xw[2] == (^xw[8:6]))
    else $error("end code info word wrong");
  a_sav_h: assert property (SAV_O && $past(SAV_O, 3) |-> xw[9] && !xw[6])
    else $error("start code info word wrong");
  a_video_range: assert property (ACTIVE_O |-> xw inside {[HDTVF_VID_MIN:HDTVF_VID_MAX]} && WORD_O.ch1 inside {[HDTVF_VID_MIN:HDTVF_VID_MAX]})
    else $error("reserved level in video");
  a_narrow_lsb: assert property (ACTIVE_O && WIDTH8_I |-> xw[1:0] == 2'b00 && WORD_O.ch1[1:0] == 2'b00)
    else $error("narrow word has fraction bits");
  a_underrun_black: assert property (UNDERRUN_O |-> ACTIVE_O && xw == HDTVF_BLACK)
    else $error("underrun word not black");
endmodule : hdtvf_formatter_chk

// ===== hdtvf_rx_model.sv
// Destination model: counts active words delivered on each line.
// Assumes formatter flags are registered on the same clock.
`timescale 1ns/1ps
module hdtvf_rx_model
  import hdtvf_pkg::*;
(
  // Clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  // Link flags in, nothing is sent back
  input  wire logic   active_i,
  input  wire logic   line_start_i,
  // Active words of the last whole line
  output logic [11:0] line_words_o
);
  logic [11:0] cnt_r;
  // Count active words, latch the total at each line start
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r        <= 12'h000;
      line_words_o <= 12'h000;
    end else if (line_start_i) begin
      cnt_r        <= 12'h000;
      line_words_o <= cnt_r;
    end else begin
      cnt_r <= cnt_r + {11'h000, active_i};
    end
  end
endmodule : hdtvf_rx_model

// ===== testbench.sv
// Self-checking bench for the HDTV line formatter in three configurations.
// Assumes checker and destination model are compiled before this file.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
  $display("unexpected %s exp %h got %h", nm, exp, got); n_errors++; end end
module testbench
  import hdtvf_pkg::*;
;
  logic        CLK_I = 1'b0, RSTN_I = 1'b0, SYS_1250_I = 1'b0, WIDTH8_I = 1'b0;
  logic        RGB_MODE_I = 1'b0, FIELD_ID_I = 1'b0, VBLANK_I = 1'b1, PIX_VALID_I = 1'b0;
  hdtvf_pix_t  PIX_DATA_I = '0;
  hdtvf_word_t WORD_O;
  logic        PIX_READY_O, ACTIVE_O, EAV_O, SAV_O, LINE_START_O, HREF_O, UNDERRUN_O;
  logic [11:0] line_words;
  int          n_errors = 0;
  int          num_checks = 0;

  always #10 CLK_I = ~CLK_I;

  hdtvf_formatter i_hdtvf_formatter (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .SYS_1250_I(SYS_1250_I),
    .WIDTH8_I(WIDTH8_I), .RGB_MODE_I(RGB_MODE_I), .FIELD_ID_I(FIELD_ID_I), .VBLANK_I(VBLANK_I),
    .PIX_VALID_I(PIX_VALID_I), .PIX_READY_O(PIX_READY_O), .PIX_DATA_I(PIX_DATA_I),
    .WORD_O(WORD_O), .ACTIVE_O(ACTIVE_O), .EAV_O(EAV_O), .SAV_O(SAV_O),
    .LINE_START_O(LINE_START_O), .HREF_O(HREF_O), .UNDERRUN_O(UNDERRUN_O));
  hdtvf_rx_model i_hdtvf_rx_model (.clk_i(CLK_I), .rst_n_i(RSTN_I), .active_i(ACTIVE_O),
    .line_start_i(LINE_START_O), .line_words_o(line_words));

  task automatic print_verdict;
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  task automatic tick;
    @(posedge CLK_I);
    #1;
  endtask : tick

  // Bounded wait for line start (sel 0) or first active word (sel 1)
  task automatic wait_on(input bit sel);
    int i;
    for (i = 0; i < 2400 && (sel ? ACTIVE_O : LINE_START_O) !== 1'b1; i++) tick;
    if (i == 2400) begin
      n_errors++;
      print_verdict;
    end
  endtask : wait_on

  // Offer one pixel, held until the edge that sees ready
  task automatic put_pix(input hdtvf_pix_t p);
    int i;
    PIX_VALID_I = 1'b1;
    PIX_DATA_I  = p;
    for (i = 0; i < 50 && PIX_READY_O !== 1'b1; i++) tick;
    if (i == 50) begin
      n_errors++;
      print_verdict;
    end
    tick;
  endtask : put_pix

  function automatic hdtvf_pix_t pix_of(input int k);
    pix_of.y_g  = (k == 2) ? 10'h000 : (k == 3) ? 10'h3FF : 10'h101 + 10'(k);
    pix_of.cb_b = (k == 4) ? 10'h3FE : 10'h181 + 10'(k);
    pix_of.cr_r = (k == 0) ? 10'h002 : 10'h281 + 10'(k);
  endfunction : pix_of

  function automatic logic [9:0] clipv(input logic [9:0] v, input logic w8);
    logic [9:0] hi;
    hi    = w8 ? HDTVF_VID_MAX8 : HDTVF_VID_MAX;
    clipv = (v < HDTVF_VID_MIN) ? HDTVF_VID_MIN : (v > hi) ? hi : v;
    if (w8) clipv = clipv & HDTVF_LSB2_MASK;
  endfunction : clipv

  // Reset into one configuration, then check codes, buffering and video words
  task automatic run_cfg(input logic sys, input logic w8, input logic rgb);
    hdtvf_pix_t p, q;
    logic       yc;
    RSTN_I = 1'b0;
    {SYS_1250_I, WIDTH8_I, RGB_MODE_I, FIELD_ID_I, VBLANK_I} = {sys, w8, rgb, 2'b01};
    repeat (20) tick;
    RSTN_I = 1'b1;
    yc = !(rgb && !sys);
    tick;
    `CHK("line_start", 1'b1, LINE_START_O)
    `CHK("eav0", (w8 && !sys) ? 10'h3FC : 10'h3FF, WORD_O.ch0)
    tick;
    `CHK("eav1", 10'h000, WORD_O.ch1)
    repeat (2) tick;
    `CHK("xyz_first", 10'h2D8, WORD_O.ch0)
    {FIELD_ID_I, VBLANK_I} = 2'b10;
    for (int k = 0; k < HDTVF_FIFO_DEPTH; k++) put_pix(pix_of(k));
    PIX_VALID_I = 1'b0;
    `CHK("ready_full", 1'b0, PIX_READY_O)
    `CHK("blank_c", yc ? HDTVF_C_ZERO : HDTVF_BLACK, WORD_O.ch1)
    wait_on(1'b1);
    for (int k = 0; k < HDTVF_FIFO_DEPTH; k++) begin
      p = pix_of(k);
      q = pix_of(k - k % 2);
      `CHK("ch0", clipv(p.y_g, w8), WORD_O.ch0)
      `CHK("ch1", clipv(yc ? (k % 2 ? q.cr_r : q.cb_b) : p.cb_b, w8), WORD_O.ch1)
      `CHK("ch2", yc ? 10'h000 : clipv(p.cr_r, w8), WORD_O.ch2)
      tick;
    end
    `CHK("underrun", 1'b1, UNDERRUN_O)
    `CHK("black", HDTVF_BLACK, WORD_O.ch0)
    wait_on(1'b0);
    repeat (3) tick;
    `CHK("xyz_next", 10'h368, WORD_O.ch0)
    `CHK("line_words", HDTVF_ACTIVE_LEN, line_words)
  endtask : run_cfg

  initial begin
    run_cfg(1'b0, 1'b0, 1'b0);
    run_cfg(1'b1, 1'b1, 1'b1);
    run_cfg(1'b0, 1'b1, 1'b1);
    print_verdict;
  end
endmodule : testbench

bind hdtvf_formatter hdtvf_formatter_chk i_hdtvf_formatter_chk (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
  .SYS_1250_I(SYS_1250_I), .WIDTH8_I(WIDTH8_I), .RGB_MODE_I(RGB_MODE_I),
  .FIELD_ID_I(FIELD_ID_I), .VBLANK_I(VBLANK_I), .PIX_VALID_I(PIX_VALID_I),
  .PIX_READY_O(PIX_READY_O), .PIX_DATA_I(PIX_DATA_I), .WORD_O(WORD_O), .ACTIVE_O(ACTIVE_O),
  .EAV_O(EAV_O), .SAV_O(SAV_O), .LINE_START_O(LINE_START_O), .HREF_O(HREF_O),
  .UNDERRUN_O(UNDERRUN_O));
